// File: testbench/vpie_chk.sv
`timescale 1ns/10ps
module vpie_chk (
	input wire        mclk,       // Clock
	input wire        rst_n,      // Reset, low
	input wire        hsel,       // Select
	input wire [31:0] haddr,      // Address
	input wire [1:0]  htrans,     // Transfer type
	input wire        hwrite,     // Write
	input wire        hready,     // Bus ready
	input wire [31:0] hrdata,     // Read data
	input wire        hreadyout,  // Slave ready
	input wire        hresp,      // Response
	input wire        frame0_src, // Event
	input wire        frame1_src, // Event
	input wire        line1_src,  // Event
	input wire        fault_src,  // Event
	input wire        frame0_irq, // Forwarded
	input wire        frame1_irq, // Forwarded
	input wire        fault_irq,  // Forwarded
	input wire        irq         // Summary
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire tk = hsel && hready && htrans[1];
	reg  wr_d;
	// High when a write lands at this edge, so registers may change
	always @(posedge mclk) wr_d <= rst_n && tk && hwrite;
	sequence rd_disarm; tk && !hwrite && haddr[7:0] == 8'h08; endsequence
	// No write may land on the two edges that feed the held output
	sequence held0;
		!wr_d ##1 frame0_irq && !wr_d ##1 frame0_src;
	endsequence
	sequence heldf;
		!wr_d ##1 fault_irq && !wr_d ##1 fault_src;
	endsequence
	AST_READY: assert property (hreadyout && !hresp)
		else $error("slave stalled or errored");
	AST_F0_SRC: assert property (frame0_irq |-> $past(frame0_src))
		else $error("frame0 irq without event");
	AST_F1_SRC: assert property (frame1_irq |->
		$past(frame1_src | line1_src))
		else $error("frame1 irq without event");
	AST_FLT_SRC: assert property (fault_irq |-> $past(fault_src))
		else $error("fault irq without event");
	AST_DISARM_RD: assert property (rd_disarm |=> hrdata == 32'h0)
		else $error("disarm register read nonzero");
	AST_HOLD0: assert property (held0 |=> frame0_irq)
		else $error("frame0 arm lost without write");
	AST_HOLDF: assert property (heldf |=> fault_irq)
		else $error("fault arm lost without write");
	AST_QUIET: assert property ($rose(rst_n) |->
		!(irq | frame0_irq | frame1_irq | fault_irq))
		else $error("outputs active after reset");
endmodule // vpie_chk
bind vpie_top vpie_chk u_chk (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.frame0_src(frame0_src), .frame1_src(frame1_src),
	.line1_src(line1_src), .fault_src(fault_src), .frame0_irq(frame0_irq),
	.frame1_irq(frame1_irq), .fault_irq(fault_irq), .irq(irq));

// File: testbench/vpie_top_tb.sv
`timescale 1ns/10ps
module vpie_top_tb;
	reg         mclk = 0;
	reg         rst_n = 0;
	reg         hsel = 0;
	reg  [31:0] haddr = 0;
	reg  [1:0]  htrans = 0;
	reg         hwrite = 0;
	reg  [31:0] hwdata = 0;
	reg  [3:0]  src = 0;
	wire [31:0] hrdata;
	wire        rdy, hresp, f0, f1, flt, irq;
	integer     bad_count = 0;
	integer     check_count = 0;
	always #5 mclk = ~mclk;
	// Sources: fault, line1, frame1, frame0
	vpie_top DUT (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(rdy), .hrdata(hrdata), .hreadyout(rdy), .hresp(hresp),
		.frame0_src(src[0]), .frame1_src(src[1]), .line1_src(src[2]),
		.fault_src(src[3]), .frame0_irq(f0), .frame1_irq(f1),
		.fault_irq(flt), .irq(irq));
	task complete_run; begin
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end endtask
	task chk(input [31:0] g, input [31:0] e); begin
		check_count = check_count + 1;
		if (g !== e) begin
			bad_count = bad_count + 1;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	end endtask
	task phase; begin
		@(posedge mclk);
		while (rdy !== 1'b1) @(posedge mclk);
	end endtask
	task addr(input [7:0] a, input w); begin
		@(posedge mclk);
		hsel <= 1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		phase;
		htrans <= 2'h0;
		hsel <= 0;
	end endtask
	task wr(input [7:0] a, input [31:0] d); begin
		addr(a, 1);
		hwdata <= d;
		phase;
	end endtask
	task rdc(input [7:0] a, input [31:0] e); begin
		addr(a, 0);
		phase;
		chk(hrdata, e);
	end endtask
	// Drive sources, then compare fault, frame1, frame0 outputs
	task ev(input [3:0] s, input [2:0] e); begin
		src <= s;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		chk({flt, f1, f0}, e);
		@(posedge mclk);
	end endtask
	task chki(input e); begin
		#1;
		chk(irq, e);
	end endtask
	task s_gate; begin
		wr(8'h04, 32'h13);
		rdc(8'h04, 32'h0);
		wr(8'h00, 32'h13);
		wr(8'h04, 32'h13);
		rdc(8'h04, 32'h13);
	end endtask
	task s_keep; begin
		wr(8'h04, 32'h0);
		rdc(8'h04, 32'h13);
		wr(8'h08, 32'h0);
		rdc(8'h04, 32'h13);
		rdc(8'h08, 32'h0);
		rdc(8'h40, 32'h0);
		ev(4'hb, 3'h7);
		ev(4'h0, 3'h0);
		wr(8'h00, 32'h12);
		rdc(8'h04, 32'h13);
		ev(4'hb, 3'h6);
		ev(4'h0, 3'h0);
		wr(8'h00, 32'h13);
	end endtask
	task s_fmt; begin
		wr(8'h0c, 32'h3);
		ev(4'h4, 3'h2);
		ev(4'h2, 3'h0);
		wr(8'h0c, 32'h0);
		ev(4'h4, 3'h0);
		ev(4'h2, 3'h2);
		ev(4'h0, 3'h0);
	end endtask
	task s_clr; begin
		wr(8'h00, 32'h01);
		wr(8'h08, 32'h12);
		wr(8'h00, 32'h13);
		rdc(8'h04, 32'h13);
		ev(4'h8, 3'h4);
		wr(8'h08, 32'h12);
		rdc(8'h04, 32'h01);
		ev(4'h8, 3'h0);
		wr(8'h08, 32'h01);
		rdc(8'h04, 32'h0);
		ev(4'h0, 3'h0);
	end endtask
	task s_irq; begin
		rdc(8'h10, 32'h7);
		wr(8'h14, 32'h7);
		rdc(8'h10, 32'h0);
		wr(8'h18, 32'h1);
		chki(0);
		wr(8'h04, 32'h2);
		rdc(8'h10, 32'h1);
		chki(1);
		wr(8'h18, 32'h0);
		chki(0);
		wr(8'h18, 32'h1);
		chki(1);
		wr(8'h14, 32'h1);
		chki(0);
	end endtask
	initial begin
		repeat (20) @(posedge mclk);
		rst_n <= 1;
		s_gate;
		s_keep;
		s_fmt;
		s_clr;
		s_irq;
		complete_run;
	end
	initial begin
		#100000;
		bad_count = bad_count + 1;
		complete_run;
	end
endmodule // vpie_top_tb

// File: verilog/vpie_arm_cell.v
`timescale 1ns/10ps
// One arm bit: set needs primary on, clear needs primary and arm on
module vpie_arm_cell (
	input  wire mclk,      // Clock
	input  wire rst_n,     // Synchronous reset, low
	input  wire primary,   // Primary enable of this source
	input  wire arm_wr,    // Write of one to its arm bit
	input  wire disarm_wr, // Write of one to its disarm bit
	output reg  arm_q,     // Armed state
	output wire ignored    // A write of one had no effect
);
	wire set_ok;
	wire clr_ok;
	reg  arm_d;

	assign set_ok = arm_wr & primary;
	assign clr_ok = disarm_wr & primary & arm_q;
	assign ignored = (arm_wr & ~set_ok) | (disarm_wr & ~clr_ok);

	always @* begin
		arm_d = arm_q;
		if (clr_ok)
			arm_d = 1'b0;
		if (set_ok)
			arm_d = 1'b1;
	end

	always @(posedge mclk) begin
		if (!rst_n)
			arm_q <= 1'b0;
		else
			arm_q <= arm_d;
	end
endmodule // vpie_arm_cell

// File: verilog/vpie_map.vh
`ifndef VPIE_MAP_VH
`define VPIE_MAP_VH
// Byte offsets on the register bus
`define VPIE_OFS_PRIMARY   8'h00
`define VPIE_OFS_ARM       8'h04
`define VPIE_OFS_DISARM    8'h08
`define VPIE_OFS_CTRL      8'h0c
`define VPIE_OFS_STAT      8'h10
`define VPIE_OFS_STAT_CLR  8'h14
`define VPIE_OFS_STAT_EN   8'h18
// Field positions within the arm/disarm/primary layout
`define VPIE_BIT_FRAME0    0
`define VPIE_BIT_FRAME1    1
`define VPIE_BIT_FAULT     4
`define VPIE_NUM_SRC       5
// Capture format field in the channel zero control word
`define VPIE_FMT_LSB       0
`define VPIE_FMT_W         2
`define VPIE_FMT_RAW       2'h3
`define VPIE_FMT_NORMAL    2'h0
// Reset values
`define VPIE_RST_ENABLE    5'h00
`define VPIE_RST_FMT       2'h0
// Event status bits (arm, disarm, ignored write)
`define VPIE_EV_ARM        0
`define VPIE_EV_DISARM     1
`define VPIE_EV_IGNORED    2
`define VPIE_NUM_EV        3
`endif

// File: verilog/vpie_top.v
`timescale 1ns/10ps
// Behaviour
// - Channel 1 arm needs its primary enable
// - Channel 0 arm needs its primary enable
// - Arm bits react only to ones
// - Armed bit holds until disarmed
// - Channel 1 disarm clears armed bit
// - Channel 0 disarm clears armed bit
// - Format raw: channel 1 arms line interrupt
// - Format zero: channel 1 arms frame interrupt
// - Fault disarm needs primary and arm
// - Effective fault disarm stops fault interrupt
// - Zeros in disarm register change nothing
// - Disarm bits 31-5 read zero
// - Fault arm needs primary fault enable
// - Channel 1 disarm needs primary and arm
`include "vpie_map.vh"
module vpie_top (
	input  wire        mclk,        // Clock, 100 MHz
	input  wire        rst_n,       // Synchronous reset, low
	input  wire        hsel,        // AHB slave select
	input  wire [31:0] haddr,       // AHB address
	input  wire [1:0]  htrans,      // AHB transfer type
	input  wire        hwrite,      // AHB write
	input  wire [2:0]  hsize,       // AHB size
	input  wire [31:0] hwdata,      // AHB write data
	input  wire        hready,      // AHB bus ready
	output reg  [31:0] hrdata,      // AHB read data
	output wire        hreadyout,   // AHB slave ready
	output wire        hresp,       // AHB response, OKAY
	input  wire        frame0_src,  // Channel 0 frame event
	input  wire        frame1_src,  // Channel 1 frame event
	input  wire        line1_src,   // Channel 1 raw line event
	input  wire        fault_src,   // Error event
	output reg         frame0_irq,  // Forwarded channel 0 frame
	output reg         frame1_irq,  // Forwarded channel 1 frame/line
	output reg         fault_irq,   // Forwarded error
	output wire        irq          // Summary event interrupt
);
	localparam N  = `VPIE_NUM_SRC;
	localparam NE = `VPIE_NUM_EV;

	reg  [N-1:0]          primary_irq_enable_q;
	reg  [`VPIE_FMT_W-1:0] chan_zero_capture_format_q;
	reg  [NE-1:0]         stat_q;
	reg  [NE-1:0]         stat_d;
	reg  [NE-1:0]         stat_en_q;
	reg                   ph_wr_q;
	reg  [7:0]            ph_addr_q;
	wire [N-1:0]          arm_q;
	wire [N-1:0]          arm_wr;
	wire [N-1:0]          disarm_wr;
	wire [N-1:0]          ign;
	wire                  take;
	wire                  wr_arm;
	wire                  wr_dis;
	wire                  ev_arm;
	wire                  ev_dis;
	wire                  ev_ign;
	wire                  frame0_primary_enable;
	wire                  frame1_primary_enable;
	wire                  fault_primary_enable;
	wire                  frame0_arm_bit;
	wire                  frame1_arm_bit;
	wire                  fault_arm_bit;
	wire                  raw_mode;
	wire                  ch1_event;
	reg  [N-1:0]          arm_prev_q;

	// Zero-wait slave: address phase captured, write applied in data phase
	assign take      = hsel & hready & htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always @(posedge mclk) begin
		if (!rst_n) begin
			ph_wr_q   <= 1'b0;
			ph_addr_q <= 8'h00;
		end else begin
			ph_wr_q   <= take & hwrite;
			ph_addr_q <= haddr[7:0];
		end
	end

	assign wr_arm = ph_wr_q & (ph_addr_q == `VPIE_OFS_ARM);
	assign wr_dis = ph_wr_q & (ph_addr_q == `VPIE_OFS_DISARM);

	// Only arm/disarm lanes that exist are wired; bits 2,3 have no source
	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : g_src
			if (g == `VPIE_BIT_FRAME0 || g == `VPIE_BIT_FRAME1 ||
			    g == `VPIE_BIT_FAULT) begin : g_cell
				assign arm_wr[g]    = wr_arm & hwdata[g];
				assign disarm_wr[g] = wr_dis & hwdata[g];
				vpie_arm_cell u_cell (
					.mclk      (mclk),
					.rst_n     (rst_n),
					.primary   (primary_irq_enable_q[g]),
					.arm_wr    (arm_wr[g]),
					.disarm_wr (disarm_wr[g]),
					.arm_q     (arm_q[g]),
					.ignored   (ign[g])
				);
			end else begin : g_none
				assign arm_wr[g]    = 1'b0;
				assign disarm_wr[g] = 1'b0;
				assign arm_q[g]     = 1'b0;
				assign ign[g]       = 1'b0;
			end
		end
	endgenerate

	assign frame0_primary_enable = primary_irq_enable_q[`VPIE_BIT_FRAME0];
	assign frame1_primary_enable = primary_irq_enable_q[`VPIE_BIT_FRAME1];
	assign fault_primary_enable  = primary_irq_enable_q[`VPIE_BIT_FAULT];
	assign frame0_arm_bit = arm_q[`VPIE_BIT_FRAME0];
	assign frame1_arm_bit = arm_q[`VPIE_BIT_FRAME1];
	assign fault_arm_bit  = arm_q[`VPIE_BIT_FAULT];

	// Channel 1 arm selects line or frame source by channel 0 format
	assign raw_mode  = (chan_zero_capture_format_q == `VPIE_FMT_RAW);
	assign ch1_event = raw_mode ? line1_src : frame1_src;

	always @(posedge mclk) begin
		if (!rst_n) begin
			frame0_irq <= 1'b0;
			frame1_irq <= 1'b0;
			fault_irq  <= 1'b0;
		end else begin
			frame0_irq <= frame0_src & frame0_primary_enable &
			              frame0_arm_bit;
			frame1_irq <= ch1_event & frame1_primary_enable &
			              frame1_arm_bit;
			fault_irq  <= fault_src & fault_primary_enable &
			              fault_arm_bit;
		end
	end

	// Primary enable and control registers
	always @(posedge mclk) begin
		if (!rst_n) begin
			primary_irq_enable_q       <= `VPIE_RST_ENABLE;
			chan_zero_capture_format_q <= `VPIE_RST_FMT;
		end else begin
			if (ph_wr_q && ph_addr_q == `VPIE_OFS_PRIMARY)
				primary_irq_enable_q <= hwdata[N-1:0];
			if (ph_wr_q && ph_addr_q == `VPIE_OFS_CTRL)
				chan_zero_capture_format_q <=
					hwdata[`VPIE_FMT_LSB +: `VPIE_FMT_W];
		end
	end

	// Sticky events; a new event wins over a clear in the same cycle
	always @(posedge mclk) begin
		if (!rst_n)
			arm_prev_q <= {N{1'b0}};
		else
			arm_prev_q <= arm_q;
	end
	assign ev_arm = |(arm_q & ~arm_prev_q);
	assign ev_dis = |(~arm_q & arm_prev_q);
	assign ev_ign = |ign;

	always @* begin
		stat_d = stat_q;
		if (ph_wr_q && ph_addr_q == `VPIE_OFS_STAT_CLR)
			stat_d = stat_q & ~hwdata[NE-1:0];
		if (ev_arm)
			stat_d[`VPIE_EV_ARM] = 1'b1;
		if (ev_dis)
			stat_d[`VPIE_EV_DISARM] = 1'b1;
		if (ev_ign)
			stat_d[`VPIE_EV_IGNORED] = 1'b1;
	end

	always @(posedge mclk) begin
		if (!rst_n) begin
			stat_q    <= {NE{1'b0}};
			stat_en_q <= {NE{1'b0}};
		end else begin
			stat_q <= stat_d;
			if (ph_wr_q && ph_addr_q == `VPIE_OFS_STAT_EN)
				stat_en_q <= hwdata[NE-1:0];
		end
	end
	assign irq = |(stat_q & stat_en_q);

	// Read data registered at the address phase so it stands in data phase
	always @(posedge mclk) begin
		if (!rst_n)
			hrdata <= 32'h0000_0000;
		else if (take && !hwrite) begin
			case (haddr[7:0])
				`VPIE_OFS_PRIMARY: hrdata <= {{(32-N){1'b0}},
				                    primary_irq_enable_q};
				`VPIE_OFS_ARM:     hrdata <= {{(32-N){1'b0}}, arm_q};
				`VPIE_OFS_DISARM:  hrdata <= 32'h0000_0000;
				`VPIE_OFS_CTRL:    hrdata <= {{(32-`VPIE_FMT_W){1'b0}},
				                    chan_zero_capture_format_q};
				`VPIE_OFS_STAT:    hrdata <= {{(32-NE){1'b0}}, stat_q};
				`VPIE_OFS_STAT_EN: hrdata <= {{(32-NE){1'b0}}, stat_en_q};
				default:           hrdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule // vpie_top
